// file: core/per_reporter.v
`timescale 1ns/1ps
`include "per_defs.vh"
module per_reporter
#(
  parameter END_CHECK_CYCLES = `PER_END_CHECK_CYC,
  parameter BLINK_CYCLES     = `PER_BLINK_CYC
)
(
  input  wire        core_clk,
  input  wire        rst,
  input  wire        simulMode,
  input  wire        autoMode,
  input  wire        manualOperatingMode,
  input  wire        stopCmd,
  input  wire [2:0]  errReset,
  input  wire [2:0]  paramErr,
  input  wire [5:0]  paramNum,
  input  wire [2:0]  startReq,
  input  wire [2:0]  progExists,
  input  wire [2:0]  lastIsProgramEndCommand,
  input  wire [2:0]  setOverflow,
  input  wire [2:0]  setOutOfRange,
  input  wire [2:0]  operandMissing,
  input  wire [2:0]  operandOtherAxis,
  input  wire [2:0]  labelMissing,
  input  wire [14:0] callDepth,
  input  wire [2:0]  callUnpaired,
  input  wire [14:0] repeatDepth,
  input  wire [2:0]  repeatUnpaired,
  input  wire [2:0]  indirectOutOfRange,
  input  wire [2:0]  bothAxisCmd,
  input  wire [1:0]  endCheckStart,
  input  wire [1:0]  axisEnabled,
  input  wire [1:0]  absolutePositionDataFail,
  input  wire [1:0]  posCompletePin,
  input  wire [1:0]  servoReadyPin,
  input  wire [1:0]  limitPin,
  input  wire        memFault,
  input  wire        sumFault,
  input  wire        watchdogExpire,
  input  wire        hwFault,
  output wire [2:0]  errFlag,
  output wire [15:0] errCodeX,
  output wire [15:0] errCodeY,
  output wire [15:0] errCodeSub,
  output reg  [1:0]  haltAxis,
  output reg  [1:0]  errLed,
  output reg         cpuFaultLed
);
  wire [5:0]  pinSync;
  wire [1:0]  posComplete;
  wire [1:0]  servoReady;
  wire [1:0]  limitHit;
  wire [47:0] slotCode;
  reg  [23:0] endCnt_reg [0:1];
  reg  [23:0] endCnt_next [0:1];
  reg  [1:0]  endFail_reg;
  reg  [1:0]  endFail_next;
  reg  [24:0] blinkCnt_reg;
  reg         blink_reg;
  reg  [18:0] cond [0:2];
  reg  [16:0] pick [0:2];
  reg  [2:0]  capture;
  reg  [47:0] captureCode;
  reg         anyGlobal;
  reg  [15:0] globalCode;
  reg         clearAll;
  integer     s;
  integer     e;

  // Six-bit binary to two-digit packed decimal
  function [7:0] toBcd;
    input [5:0] n;
    reg   [5:0] tens;
    reg   [5:0] ones;
    begin
      tens  = n / 6'h0A;
      ones  = n - tens * 6'h0A;
      toBcd = {tens[3:0], ones[3:0]};
    end
  endfunction

  function nestOver;
    input [4:0] depth;
    begin
      nestOver = depth > `PER_NEST_MAX;
    end
  endfunction

  // Highest-priority fault wins: critical, external, program, parameter.
  // Returns {global, code}; scope depends on the operating mode.
  function [16:0] pickCode;
    input [18:0] c;
    input        simul;
    input [5:0]  pnum;
    begin
      if (c[0])
        pickCode = {1'b1, `PER_CODE_MEMORY};
      else if (c[1])
        pickCode = {1'b1, `PER_CODE_SUM};
      else if (c[2])
        pickCode = {1'b1, `PER_CODE_WATCHDOG};
      else if (c[3])
        pickCode = {1'b1, `PER_CODE_HARDWARE};
      else if (c[4])
        pickCode = {1'b0, `PER_CODE_SERVO_END};
      else if (c[5])
        pickCode = {1'b0, `PER_CODE_SERVO_RDY};
      else if (c[6])
        pickCode = {1'b0, `PER_CODE_LIMIT};
      else if (c[7])
        pickCode = {1'b0, `PER_CODE_ABS_XFER};
      else if (c[8])
        pickCode = {simul, `PER_CODE_NO_PROG};
      else if (c[9])
        pickCode = {simul, `PER_CODE_NO_END};
      else if (c[10])
        pickCode = {1'b0, `PER_CODE_OVERFLOW};
      else if (c[11])
        pickCode = {1'b0, `PER_CODE_RANGE};
      else if (c[12])
        pickCode = {1'b0, `PER_CODE_OPERAND};
      else if (c[13])
        pickCode = {simul, `PER_CODE_LABEL};
      else if (c[14])
        pickCode = {simul, `PER_CODE_CALL};
      else if (c[15])
        pickCode = {simul, `PER_CODE_REPEAT};
      else if (c[16])
        pickCode = {simul, `PER_CODE_INDIRECT};
      else if (c[17])
        pickCode = {1'b1, `PER_CODE_AXIS_MIX};
      else if (c[18])
        pickCode = {1'b0, `PER_CODE_PARAM | {8'h00, toBcd(pnum)}};
      else
        pickCode = {1'b0, `PER_CODE_NONE};
    end
  endfunction

  per_pin_sync #(.W(6)) u_sync
  (
    .core_clk (core_clk),
    .rst      (rst),
    .pinIn    ({limitPin, servoReadyPin, posCompletePin}),
    .pinOut   (pinSync)
  );

  assign posComplete = pinSync[1:0];
  assign servoReady  = pinSync[3:2];
  assign limitHit    = pinSync[5:4];

  // Servo end check: the window opens on the start pulse and fails
  // if positioning-complete never shows before it runs out
  always @*
  begin
    endFail_next = 2'b00;
    for (e = 0; e < 2; e = e + 1)
    begin
      endCnt_next[e] = endCnt_reg[e];
      if (endCheckStart[e])
        endCnt_next[e] = END_CHECK_CYCLES[23:0];
      else if (endCnt_reg[e] != 24'h00_0000)
      begin
        if (posComplete[e])
          endCnt_next[e] = 24'h00_0000;
        else
        begin
          endCnt_next[e] = endCnt_reg[e] - 24'h00_0001;
          endFail_next[e] = (endCnt_reg[e] == 24'h00_0001);
        end
      end
    end
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      endCnt_reg[0] <= 24'h00_0000;
      endCnt_reg[1] <= 24'h00_0000;
      endFail_reg   <= 2'b00;
    end
    else
    begin
      endCnt_reg[0] <= endCnt_next[0];
      endCnt_reg[1] <= endCnt_next[1];
      endFail_reg   <= endFail_next;
    end
  end

  // Fault classification for X, Y and the subtask
  always @*
  begin
    anyGlobal   = 1'b0;
    globalCode  = `PER_CODE_NONE;
    capture     = 3'b000;
    captureCode = 48'h0000_0000_0000;
    clearAll    = manualOperatingMode & stopCmd;
    for (s = 0; s < 3; s = s + 1)
    begin
      cond[s][0]  = memFault;
      cond[s][1]  = sumFault;
      cond[s][2]  = watchdogExpire;
      cond[s][3]  = hwFault;
      cond[s][4]  = (s < 2) ? endFail_reg[s] : 1'b0;
      cond[s][5]  = (s < 2) ? (axisEnabled[s] & ~servoReady[s]) : 1'b0;
      cond[s][6]  = (s < 2) ? limitHit[s] : 1'b0;
      cond[s][7]  = (s < 2) ? absolutePositionDataFail[s] : 1'b0;
      cond[s][8]  = startReq[s] & autoMode & ~progExists[s];
      cond[s][9]  = startReq[s] & autoMode & progExists[s]
                    & ~lastIsProgramEndCommand[s];
      cond[s][10] = setOverflow[s];
      cond[s][11] = setOutOfRange[s];
      cond[s][12] = operandMissing[s] | operandOtherAxis[s];
      cond[s][13] = labelMissing[s];
      cond[s][14] = nestOver(callDepth[s*5 +: 5]) | callUnpaired[s];
      cond[s][15] = nestOver(repeatDepth[s*5 +: 5]) | repeatUnpaired[s];
      cond[s][16] = indirectOutOfRange[s];
      cond[s][17] = bothAxisCmd[s] & ~simulMode;
      cond[s][18] = paramErr[s] & (paramNum <= `PER_PARAM_MAX);
      pick[s]     = pickCode(cond[s], simulMode, paramNum);
      if (pick[s][16] && !anyGlobal)
      begin
        anyGlobal  = 1'b1;
        globalCode = pick[s][15:0];
      end
    end
    // Own fault first; a global fault elsewhere fills the rest
    for (s = 0; s < 3; s = s + 1)
    begin
      if (|cond[s])
      begin
        capture[s] = 1'b1;
        captureCode[s*16 +: 16] = pick[s][15:0];
      end
      else if (anyGlobal)
      begin
        capture[s] = 1'b1;
        captureCode[s*16 +: 16] = globalCode;
      end
    end
  end

  per_err_slot u_slot_x
  (
    .core_clk (core_clk),
    .rst      (rst),
    .capture  (capture[0]),
    .codeIn   (captureCode[15:0]),
    .clear    (errReset[0] | clearAll),
    .errFlag  (errFlag[0]),
    .errCode  (slotCode[15:0])
  );

  per_err_slot u_slot_y
  (
    .core_clk (core_clk),
    .rst      (rst),
    .capture  (capture[1]),
    .codeIn   (captureCode[31:16]),
    .clear    (errReset[1] | clearAll),
    .errFlag  (errFlag[1]),
    .errCode  (slotCode[31:16])
  );

  per_err_slot u_slot_sub
  (
    .core_clk (core_clk),
    .rst      (rst),
    .capture  (capture[2]),
    .codeIn   (captureCode[47:32]),
    .clear    (errReset[2] | clearAll),
    .errFlag  (errFlag[2]),
    .errCode  (slotCode[47:32])
  );

  assign errCodeX   = slotCode[15:0];
  assign errCodeY   = slotCode[31:16];
  assign errCodeSub = slotCode[47:32];

  // Flash clock for external faults; free running so both LEDs stay in step
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      blinkCnt_reg <= 25'h000_0000;
      blink_reg    <= 1'b0;
    end
    else if (blinkCnt_reg >= BLINK_CYCLES[24:0] - 25'h000_0001)
    begin
      blinkCnt_reg <= 25'h000_0000;
      blink_reg    <= ~blink_reg;
    end
    else
      blinkCnt_reg <= blinkCnt_reg + 25'h000_0001;
  end

  // Halt follows the stored flags, so a halt lasts exactly as long as the error
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      haltAxis    <= 2'b00;
      errLed      <= 2'b00;
      cpuFaultLed <= 1'b0;
    end
    else
    begin
      haltAxis[0] <= errFlag[0] | (simulMode & errFlag[1]);
      haltAxis[1] <= errFlag[1] | (simulMode & errFlag[0]);
      errLed[0]   <= errFlag[0] & ((errCodeX[15:12] != `PER_CLASS_EXT) | blink_reg);
      errLed[1]   <= errFlag[1] & ((errCodeY[15:12] != `PER_CLASS_EXT) | blink_reg);
      cpuFaultLed <= (errCodeX == `PER_CODE_WATCHDOG) | (errCodeY == `PER_CODE_WATCHDOG)
                     | (errCodeSub == `PER_CODE_WATCHDOG);
    end
  end
endmodule

// file: core/per_defs.vh
// How it works
// - Bad parameter reports 2000 plus its number
// - Start with missing program raises 3000
// - Program without end command raises 3001
// - Set value past 32 bits: local 3003
// - Set value out of range raises 3004
// - Missing or foreign-axis operand raises 3005
// - Missing call or jump label raises 3006
// - Call nest over 15 or unpaired: 3007
// - Repeat nest over 15 or unpaired: 3008
// - Indirect program number out of range: 3009
// - Mixed axes in independent program: global 3010
// - No positioning-complete at servo check: 4002
// - Amplifier ready missing raises local 4003
// - Position data fail 4006, limit 4004, flashing
// - Critical faults 9000 to 9003 always global
// - Global error flags and halts both axes
// - Local error flags only its own axis
// - Local X or Y error in simultaneous mode halts both
// - Local X or Y error in independent mode halts one
// - Per-slot error flag and stored code
`ifndef PER_DEFS_VH
`define PER_DEFS_VH

`define PER_CLK_NS          10
`define PER_END_CHECK_MS    100
`define PER_END_CHECK_CYC   ((`PER_END_CHECK_MS * 1000000) / `PER_CLK_NS)
`define PER_BLINK_MS        250
`define PER_BLINK_CYC       ((`PER_BLINK_MS * 1000000) / `PER_CLK_NS)
`define PER_NEST_MAX        5'h0F
`define PER_PARAM_MAX       6'h38

`define PER_CODE_NONE       16'h0000
`define PER_CODE_PARAM      16'h2000
`define PER_CODE_NO_PROG    16'h3000
`define PER_CODE_NO_END     16'h3001
`define PER_CODE_OVERFLOW   16'h3003
`define PER_CODE_RANGE      16'h3004
`define PER_CODE_OPERAND    16'h3005
`define PER_CODE_LABEL      16'h3006
`define PER_CODE_CALL       16'h3007
`define PER_CODE_REPEAT     16'h3008
`define PER_CODE_INDIRECT   16'h3009
`define PER_CODE_AXIS_MIX   16'h3010
`define PER_CODE_SERVO_END  16'h4002
`define PER_CODE_SERVO_RDY  16'h4003
`define PER_CODE_LIMIT      16'h4004
`define PER_CODE_ABS_XFER   16'h4006
`define PER_CODE_MEMORY     16'h9000
`define PER_CODE_SUM        16'h9001
`define PER_CODE_WATCHDOG   16'h9002
`define PER_CODE_HARDWARE   16'h9003
`define PER_CLASS_EXT       4'h4

`endif

// file: core/per_pin_sync.v
`timescale 1ns/1ps
module per_pin_sync
#(
  parameter W = 6
)
(
  input  wire         core_clk,
  input  wire         rst,
  input  wire [W-1:0] pinIn,
  output reg  [W-1:0] pinOut
);
  reg [W-1:0] stage1_reg;
  reg [W-1:0] stage2_reg;
  reg [W-1:0] stage3_reg;

  // A change is accepted only when the second and third stages agree.
  // Stages keep sampling through reset so the output starts at the pin's level;
  // a cleared output would read as a dropped ready pin right after reset.
  always @(posedge core_clk)
  begin
    stage1_reg <= pinIn;
    stage2_reg <= stage1_reg;
    stage3_reg <= stage2_reg;
    if (rst)
      pinOut <= stage2_reg;
    else
      pinOut <= (stage2_reg & stage3_reg) | (pinOut & (stage2_reg ^ stage3_reg));
  end
endmodule

// file: core/per_err_slot.v
`timescale 1ns/1ps
`include "per_defs.vh"
module per_err_slot
(
  input  wire        core_clk,
  input  wire        rst,
  input  wire        capture,
  input  wire [15:0] codeIn,
  input  wire        clear,
  output reg         errFlag,
  output reg  [15:0] errCode
);
  // First fault is kept; a fault arriving with the clear still lands
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      errFlag <= 1'b0;
      errCode <= `PER_CODE_NONE;
    end
    else if (capture && (!errFlag || clear))
    begin
      errFlag <= 1'b1;
      errCode <= codeIn;
    end
    else if (clear)
    begin
      errFlag <= 1'b0;
      errCode <= `PER_CODE_NONE;
    end
  end
endmodule

// file: sim/per_reporter_properties.sv
`timescale 1ns/1ps
module per_reporter_properties
(
  input wire        core_clk,
  input wire        rst,
  input wire        simulMode,
  input wire        manualOperatingMode,
  input wire        stopCmd,
  input wire [2:0]  errReset,
  input wire        memFault,
  input wire [2:0]  errFlag,
  input wire [15:0] errCodeX,
  input wire [15:0] errCodeY,
  input wire [15:0] errCodeSub,
  input wire [1:0]  haltAxis,
  input wire        cpuFaultLed
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire clrAll = manualOperatingMode & stopCmd;
  wire wdHeld = errCodeX == 16'h9002 || errCodeY == 16'h9002 || errCodeSub == 16'h9002;

  chk_critical_global: assert property (
    errFlag == 3'b000 && memFault |=> errFlag == 3'b111 && errCodeY == 16'h9000
    && errCodeSub == 16'h9000) else $error("critical fault not global");
  chk_watchdog_led: assert property (
    cpuFaultLed == $past(wdHeld)) else $error("processor fault lamp wrong");
  chk_idle_code: assert property (
    !errFlag[0] |-> errCodeX == 16'h0000) else $error("idle code not zero");
  chk_code_hold: assert property (
    errFlag[0] && !errReset[0] && !clrAll |=> errFlag[0] && $stable(errCodeX))
    else $error("held code changed");
  chk_drop_cause: assert property (
    $fell(errFlag[1]) && !$past(rst) |-> $past(errReset[1] | clrAll))
    else $error("flag dropped without clear");
  chk_halt_both: assert property (
    simulMode && errFlag[1:0] != 2'b00 |=> haltAxis == 2'b11)
    else $error("both axes not halted");
  chk_halt_one: assert property (
    !simulMode && errFlag[1:0] == 2'b10 |=> haltAxis == 2'b10)
    else $error("wrong axis halted");
  chk_halt_free: assert property (
    errFlag[1:0] == 2'b00 |=> haltAxis == 2'b00) else $error("halt without error");
  cover property (errFlag == 3'b111);
  cover property (haltAxis == 2'b01);
  cover property (cpuFaultLed);
endmodule

bind per_reporter per_reporter_properties u_props
(
  .core_clk(core_clk), .rst(rst), .simulMode(simulMode), .stopCmd(stopCmd),
  .manualOperatingMode(manualOperatingMode), .errReset(errReset), .memFault(memFault),
  .errFlag(errFlag), .errCodeX(errCodeX), .errCodeY(errCodeY), .errCodeSub(errCodeSub),
  .haltAxis(haltAxis), .cpuFaultLed(cpuFaultLed)
);

// file: sim/per_amp_model.sv
`timescale 1ns/1ps
module per_amp_model
(
  input  wire       core_clk,
  input  wire [1:0] checkStart,
  input  wire [1:0] slowDone,
  input  wire [1:0] dropReady,
  input  wire [1:0] limitHit,
  output wire [1:0] posComplete,
  output wire [1:0] servoReady,
  output wire [1:0] limitSw
);
  integer cnt [0:1] = '{0, 0};
  integer i;
  // Slow settling holds completion low until released, well past the check window
  assign posComplete = {cnt[1] == 0 && !slowDone[1], cnt[0] == 0 && !slowDone[0]};
  assign servoReady  = ~dropReady;
  assign limitSw     = limitHit;
  always @(posedge core_clk)
    for (i = 0; i < 2; i = i + 1)
      if (checkStart[i])
        cnt[i] <= 5;
      else if (cnt[i] > 0)
        cnt[i] <= cnt[i] - 1;
endmodule

// file: sim/per_reporter_tb.sv
`timescale 1ns/1ps
module per_reporter_tb;
  reg         core_clk;
  reg         rst = 1'b1;
  reg         sim = 1'b0;
  reg         manual = 1'b0;
  reg         stop = 1'b0;
  reg         autoOn = 1'b1;
  reg  [1:0]  axisEn = 2'b11;
  reg  [2:0]  errReset = 3'b000;
  reg  [2:0]  f [0:10] = '{default: 3'b000};
  reg  [5:0]  paramNum = 6'h00;
  reg  [14:0] callDepth = 15'h0000;
  reg  [14:0] repeatDepth = 15'h0000;
  reg  [1:0]  checkStart = 2'b00;
  reg  [1:0]  absFail = 2'b00;
  reg  [1:0]  slow = 2'b00;
  reg  [1:0]  dropRdy = 2'b00;
  reg  [1:0]  limHit = 2'b00;
  reg  [3:0]  crit = 4'h0;
  reg         lastLed;
  wire [1:0]  posDone;
  wire [1:0]  rdy;
  wire [1:0]  lim;
  wire [2:0]  errFlag;
  wire [15:0] codeX;
  wire [15:0] codeY;
  wire [15:0] codeSub;
  wire [1:0]  haltAxis;
  wire [1:0]  errLed;
  wire        cpuLed;
  integer     cur = 0;
  integer     ex [0:2] = '{0, 0, 0};
  integer     bad_count = 0;
  integer     total_checks = 0;
  integer     cyc = 0;
  integer     i, m, s, n, a, k, tog;

  per_reporter #(.END_CHECK_CYCLES(20), .BLINK_CYCLES(4)) DUT
  (
    .core_clk(core_clk), .rst(rst), .simulMode(sim), .autoMode(autoOn),
    .manualOperatingMode(manual), .stopCmd(stop), .errReset(errReset), .paramErr(f[8]),
    .paramNum(paramNum), .startReq(f[9] | f[10]), .progExists(cur == 9 ? 3'b000 : 3'b111),
    .lastIsProgramEndCommand(cur == 10 ? 3'b000 : 3'b111), .setOverflow(f[0]),
    .setOutOfRange(f[1]), .operandMissing(f[2]), .operandOtherAxis(3'b000),
    .labelMissing(f[3]), .callDepth(callDepth), .callUnpaired(f[4]),
    .repeatDepth(repeatDepth), .repeatUnpaired(f[5]), .indirectOutOfRange(f[6]),
    .bothAxisCmd(f[7]), .endCheckStart(checkStart), .axisEnabled(axisEn),
    .absolutePositionDataFail(absFail), .posCompletePin(posDone), .servoReadyPin(rdy),
    .limitPin(lim), .memFault(crit[0]), .sumFault(crit[1]), .watchdogExpire(crit[2]),
    .hwFault(crit[3]), .errFlag(errFlag), .errCodeX(codeX), .errCodeY(codeY),
    .errCodeSub(codeSub), .haltAxis(haltAxis), .errLed(errLed), .cpuFaultLed(cpuLed)
  );
  per_amp_model u_amp
  (
    .core_clk(core_clk), .checkStart(checkStart), .slowDone(slow), .dropReady(dropRdy),
    .limitHit(limHit), .posComplete(posDone), .servoReady(rdy), .limitSw(lim)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 6000)
    begin
      bad_count = bad_count + 1;
      summarize;
    end
  end

  task summarize;
  begin
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask

  task chk(input [31:0] got, input [31:0] want);
  begin
    total_checks = total_checks + 1;
    if (got !== want)
    begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  end
  endtask

  task fire(input integer s, input integer c, input integer g);
    integer j;
  begin
    for (j = 0; j < 3; j = j + 1)
      if ((g || j == s) && ex[j] == 0)
        ex[j] = c;
  end
  endtask

  task step;
  begin
    repeat (3) @(negedge core_clk);
    chk(codeX, ex[0]);
    chk(codeY, ex[1]);
    chk(codeSub, ex[2]);
    chk(errFlag, {ex[2] != 0, ex[1] != 0, ex[0] != 0});
    chk(haltAxis, {ex[1] != 0 || sim && ex[0] != 0, ex[0] != 0 || sim && ex[1] != 0});
  end
  endtask

  task clr(input integer s);
  begin
    errReset[s] = 1'b1;
    @(negedge core_clk);
    errReset = 3'b000;
    ex[s] = 0;
    step;
    manual = 1'b1;
    stop = 1'b1;
    @(negedge core_clk);
    manual = 1'b0;
    stop = 1'b0;
    ex = '{0, 0, 0};
    step;
  end
  endtask

  initial
  begin
    n = $urandom(32'hc5850e5f);
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    step;
    // Start outside auto mode and lost ready on disabled axes stay silent
    autoOn = 1'b0;
    cur = 9;
    axisEn = 2'b00;
    dropRdy = 2'b11;
    f[9] = 3'b111;
    @(negedge core_clk);
    f[9] = 3'b000;
    repeat (6) @(negedge core_clk);
    step;
    autoOn = 1'b1;
    dropRdy = 2'b00;
    repeat (6) @(negedge core_clk);
    axisEn = 2'b11;
    // Table index: 0..6 codes 3003..3009, 7 mixed axes, 8 parameter, 9 and 10 start faults
    for (m = 0; m < 2; m = m + 1)
      for (i = 0; i < 11; i = i + 1)
        for (s = 0; s < 3; s = s + 1)
          if (!(i == 7 && m == 1))
          begin
            sim = m;
            cur = i;
            n = $urandom % 57;
            paramNum = n;
            f[i][s] = 1'b1;
            @(negedge core_clk);
            f[i] = 3'b000;
            fire(s, i < 7 ? 16'h3003 + i : i == 7 ? 16'h3010 : i == 8 ?
              16'h2000 + n / 10 * 16 + n % 10 : 16'h2FF7 + i,
              i == 7 || m && (i > 2 && i < 7 || i > 8));
            step;
            f[0][s] = 1'b1;
            @(negedge core_clk);
            f[0] = 3'b000;
            step;
            clr(s);
          end
    sim = 0;
    cur = 0;
    for (a = 0; a < 2; a = a + 1)
      for (k = 0; k < 5; k = k + 1)
      begin
        slow[a] = k == 1;
        dropRdy[a] = k == 2;
        limHit[a] = k == 3;
        repeat (5) @(negedge core_clk);
        absFail[a] = k == 4;
        checkStart[a] = k < 2;
        @(negedge core_clk);
        absFail = 2'b00;
        checkStart = 2'b00;
        tog = 0;
        lastLed = errLed[a];
        repeat (60)
        begin
          @(negedge core_clk);
          tog = tog + (errLed[a] !== lastLed);
          lastLed = errLed[a];
        end
        if (k > 0)
          fire(a, k == 4 ? 16'h4006 : 16'h4001 + k, 0);
        step;
        chk(tog > 2, k > 0);
        slow = 2'b00;
        dropRdy = 2'b00;
        limHit = 2'b00;
        repeat (6) @(negedge core_clk);
        clr(a);
      end
    callDepth = 15'h000F;
    repeatDepth = 15'h01E0;
    step;
    callDepth = 15'h0010;
    repeatDepth = 15'h0200;
    @(negedge core_clk);
    callDepth = 15'h0000;
    repeatDepth = 15'h0000;
    fire(0, 16'h3007, 0);
    fire(1, 16'h3008, 0);
    step;
    clr(0);
    for (k = 0; k < 4; k = k + 1)
    begin
      sim = k % 2;
      crit[k] = 1'b1;
      @(negedge core_clk);
      crit = 4'h0;
      fire(0, 16'h9000 + k, 1);
      step;
      chk(cpuLed, k == 2);
      clr(2);
    end
    summarize;
  end
endmodule
